// >>> shared/dess_pkg.sv
// Constants and types shared by the drive enable safety supervisor
package dess_pkg;
	// Timing
	localparam int unsigned CLK_HZ    = 50_000_000;
	localparam int unsigned WIN_S     = 3;    // Supervision window, s
	localparam int unsigned WIN_CYC   = WIN_S * CLK_HZ;
	localparam int unsigned ENSEQ_MS  = 100;  // Enable sequencing delay
	localparam int unsigned ENSEQ_CYC = ENSEQ_MS * (CLK_HZ / 1000);
	localparam int unsigned CUR_PCT   = 25;   // Decay threshold, percent
	localparam int unsigned DIN_N     = 8;    // Routable digital inputs

	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TRIP = 8'h08;
	localparam logic [7:0] A_LOG  = 8'h0c;
	localparam logic [7:0] A_RST  = 8'h10;

	// Control field positions
	localparam int unsigned CTRL_QD_EN  = 0;
	localparam int unsigned CTRL_CF_EN  = 1;
	localparam int unsigned CTRL_QD_SEL = 4;
	localparam int unsigned CTRL_CF_SEL = 8;
	localparam int unsigned RST_BIT     = 0;

	// Status field positions
	localparam int unsigned ST_TC   = 0;
	localparam int unsigned ST_QD   = 1;
	localparam int unsigned ST_CF   = 2;
	localparam int unsigned ST_TRIP = 3;
	localparam int unsigned ST_GATE = 4;
	localparam int unsigned ST_CMD  = 5;
	localparam int unsigned ST_WIN  = 6;
	localparam int unsigned TR_ACT  = 8;

	// Trip codes and bus answers
	localparam logic [7:0] TRIP_NONE = 8'h00;
	localparam logic [7:0] TRIP_TC   = 8'h4b;
	localparam logic [7:0] TRIP_QD   = 8'h4a;
	localparam logic [7:0] TRIP_CUR  = 8'h48;
	localparam logic [7:0] TRIP_CF   = 8'h4e;
	localparam logic [1:0] RESP_OK   = 2'h0;
	localparam logic [1:0] RESP_ERR  = 2'h2;

	typedef struct packed {
		logic [2:0] cf_sel;  // Input routed to contactor_feedback
		logic [2:0] qd_sel;  // Input routed by quick_disable_route
		logic       cf_en;   // contactor_monitor_enable
		logic       qd_en;   // Quick-disable input in use
	} dess_ctrl_t;

	localparam dess_ctrl_t CTRL_RST = '0;

	typedef enum logic [1:0] {W_IDLE, W_START, W_RUN, W_STOP} dess_win_t;
endpackage

// >>> logic/dess_supervisor.sv
// Drive enable supervisor: window checks, trips, AXI4-Lite registers
`timescale 1ns/100ps
// Summary of operation
// - Start needs cutoff, quick-disable closed within 3 s
// - Stop needs inputs open, current below 25%
// - Cutoff or speed sequence fault trips 75
// - Quick-disable state or routing fault trips 74
// - Missing current decay trips code 72
// - Trip logged, drive held off until reset
// - Feedback high when released, low when closed
// - Feedback late by 3 s trips 78
// - Contactor check only when enabled, routed input
// - Torque only while cutoff input is high
// - Quick-disable stops output under 650 us
// - Quick-disable works only when enabled, any routed input
// - Cutoff input state readable in status
// - Relay stuck closed after travel blocks next
// - Open cutoff switches all transistors off
// - Open cutoff blocks drive despite internal faults
// - Enable sequencing waits 100 ms after cutoff
module dess_supervisor #(
	parameter int unsigned WIN_CYC   = dess_pkg::WIN_CYC,   // 3 s window
	parameter int unsigned ENSEQ_CYC = dess_pkg::ENSEQ_CYC, // 100 ms
	parameter int unsigned CUR_W     = 12,                  // Current width
	parameter int unsigned CUR_FS    = 4095                 // Full scale
) (
	input  wire logic             i_core_clk,        // Core clock
	input  wire logic             i_rst_n,           // Async reset
	input  wire logic [7:0]       i_s_axi_awaddr,    // Write address
	input  wire logic             i_s_axi_awvalid,   // Write addr valid
	output logic                  o_s_axi_awready,   // Write addr ready
	input  wire logic [31:0]      i_s_axi_wdata,     // Write data
	input  wire logic [3:0]       i_s_axi_wstrb,     // Byte strobes
	input  wire logic             i_s_axi_wvalid,    // Write data valid
	output logic                  o_s_axi_wready,    // Write data ready
	output logic [1:0]            o_s_axi_bresp,     // Write response
	output logic                  o_s_axi_bvalid,    // Response valid
	input  wire logic             i_s_axi_bready,    // Response ready
	input  wire logic [7:0]       i_s_axi_araddr,    // Read address
	input  wire logic             i_s_axi_arvalid,   // Read addr valid
	output logic                  o_s_axi_arready,   // Read addr ready
	output logic [31:0]           o_s_axi_rdata,     // Read data
	output logic [1:0]            o_s_axi_rresp,     // Read response
	output logic                  o_s_axi_rvalid,    // Read data valid
	input  wire logic             i_s_axi_rready,    // Read data ready
	input  wire logic             i_torque_cutoff_input, // Pin, high=run
	input  wire logic [2:0]       i_speed_sel,       // Speed selection
	input  wire logic [7:0]       i_din,             // Routable inputs
	input  wire logic [CUR_W-1:0] i_motor_current,   // Current sample
	output logic                  o_gate_enable,     // Power stage on
	output logic                  o_contactor_cmd,   // Close contactor
	output logic                  o_tripped,         // Trip latched
	output logic [7:0]            o_trip_code        // Active trip code
);
	localparam int unsigned CW = $clog2(WIN_CYC);
	localparam int unsigned EW = $clog2(ENSEQ_CYC + 1);
	localparam int unsigned PW = dess_pkg::DIN_N + 4;
	localparam logic [CW-1:0] WIN_LAST = CW'(WIN_CYC - 1);
	localparam logic [EW-1:0] EN_DONE  = EW'(ENSEQ_CYC);
	localparam logic [CUR_W-1:0] CUR_TH =
		CUR_W'(CUR_FS * dess_pkg::CUR_PCT / 100);

	logic rs1_q, rst_n;
	logic [PW-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
	dess_pkg::dess_ctrl_t ctrl_q, ctrl_d;
	dess_pkg::dess_win_t  st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d, cf_cnt_q, cf_cnt_d;
	logic [EW-1:0] en_q, en_d;
	logic [2:0] spd, spdp_q;
	logic [7:0] din, code_q, code_d, wcode, set_code;
	logic [31:0] log_q, log_d;
	logic tc, qd_in, cf_in, qd_ok, qd_off, cur_low;
	logic start_met, stop_met, start_ev, stop_ev, sel_chg, expire;
	logic wset, cset, set_any, clr, mism;
	logic trip_q, trip_d, gate_q, gate_d, cmd_q, cmd_d;
	logic awf_q, awf_d, wf_q, wf_d, bv_q, bv_d, rv_q, rv_d, wr_go;
	logic aw_hs, w_hs, ar_hs;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	// Routed input selection, shared by both routing fields
	function automatic logic pick(input logic [7:0] v,
		input logic [2:0] s);
		return v[s];
	endfunction

	// Only five word offsets answer OKAY
	function automatic logic is_map(input logic [7:0] a);
		return a == dess_pkg::A_CTRL || a == dess_pkg::A_STAT ||
			a == dess_pkg::A_TRIP || a == dess_pkg::A_LOG ||
			a == dess_pkg::A_RST;
	endfunction

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rs1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_n <= rs1_q;
		end
	end

	// Pins change only once the last two stages agree (glitch filter)
	always_comb pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			pin_q <= '0;
		end else begin
			s1_q  <= {i_torque_cutoff_input, i_speed_sel, i_din};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			pin_q <= pin_d;
		end
	end

	// Decoded conditions
	assign tc   = pin_q[PW-1];
	assign spd  = pin_q[PW-2 -: 3];
	assign din  = pin_q[dess_pkg::DIN_N-1:0];
	assign qd_in  = pick(din, ctrl_q.qd_sel);
	assign cf_in  = pick(din, ctrl_q.cf_sel);
	assign qd_ok  = !ctrl_q.qd_en || qd_in;
	assign qd_off = !ctrl_q.qd_en || !qd_in;
	assign cur_low   = i_motor_current < CUR_TH;
	assign start_met = tc && qd_ok;
	assign stop_met  = !tc && qd_off && cur_low;
	assign start_ev  = spd != 3'h0 && spdp_q == 3'h0;
	assign stop_ev   = spd == 3'h0 && spdp_q != 3'h0;
	assign sel_chg   = spd != 3'h0 && spdp_q != 3'h0 && spd != spdp_q;
	assign expire    = cnt_q == WIN_LAST;

	// Start and stop supervision windows
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q + 1'b1;
		wset  = 1'b0;
		wcode = dess_pkg::TRIP_NONE;
		unique case (st_q)
			dess_pkg::W_IDLE: begin
				cnt_d = '0;
				if (start_ev)
					st_d = dess_pkg::W_START;
			end
			dess_pkg::W_START: begin
				if (stop_ev) begin
					st_d  = dess_pkg::W_STOP;
					cnt_d = '0;
				end else if (sel_chg) begin
					wset  = 1'b1;
					wcode = dess_pkg::TRIP_TC;
				end else if (start_met) begin
					st_d  = dess_pkg::W_RUN;
					cnt_d = '0;
				end else if (expire) begin
					wset  = 1'b1;
					wcode = !tc ? dess_pkg::TRIP_TC : dess_pkg::TRIP_QD;
				end
			end
			dess_pkg::W_RUN: begin
				cnt_d = '0;
				if (stop_ev)
					st_d = dess_pkg::W_STOP;
			end
			dess_pkg::W_STOP: begin
				if (start_ev) begin
					wset  = 1'b1;
					wcode = dess_pkg::TRIP_TC;
				end else if (stop_met) begin
					st_d  = dess_pkg::W_IDLE;
					cnt_d = '0;
				end else if (expire) begin
					wset = 1'b1;
					if (tc)
						wcode = dess_pkg::TRIP_TC;
					else if (!qd_off)
						wcode = dess_pkg::TRIP_QD;
					else
						wcode = dess_pkg::TRIP_CUR;
				end
			end
		endcase
		if (trip_q || wset) begin
			st_d  = dess_pkg::W_IDLE;
			cnt_d = '0;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= dess_pkg::W_IDLE;
			cnt_q  <= '0;
			spdp_q <= 3'h0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			spdp_q <= spd;
		end
	end

	// Contactor command follows travel; feedback must be its inverse
	always_comb begin
		cmd_d = st_d == dess_pkg::W_START || st_d == dess_pkg::W_RUN;
		mism  = ctrl_q.cf_en && (cf_in == cmd_q);
		// timer restarts on every command change
		cf_cnt_d = (!mism || cmd_d != cmd_q || trip_q) ? '0 :
			cf_cnt_q + 1'b1;
		cset = mism && cf_cnt_q == WIN_LAST && !trip_q;
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q    <= 1'b0;
			cf_cnt_q <= '0;
		end else begin
			cmd_q    <= cmd_d;
			cf_cnt_q <= cf_cnt_d;
		end
	end

	// Trip latch and log; a new trip beats a reset in the same cycle
	always_comb begin
		set_any  = !trip_q && (wset || cset);
		set_code = wset ? wcode : dess_pkg::TRIP_CF;
		trip_d   = trip_q;
		code_d   = code_q;
		log_d    = log_q;
		if (set_any) begin
			trip_d = 1'b1;
			code_d = set_code;
			log_d  = {log_q[23:0], set_code};
		end else if (clr && !wset && !cset) begin
			trip_d = 1'b0;
			code_d = dess_pkg::TRIP_NONE;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trip_q <= 1'b0;
			code_q <= dess_pkg::TRIP_NONE;
			log_q  <= '0;
		end else begin
			trip_q <= trip_d;
			code_q <= code_d;
			log_q  <= log_d;
		end
	end

	// Output stage gating; no software path can hold it on
	always_comb begin
		if (!tc)
			en_d = '0;
		else
			en_d = (en_q == EN_DONE) ? en_q : en_q + 1'b1;
		// cutoff, quick-disable, trip
		// Next trip state, so the stage drops on the trip edge itself
		gate_d = tc && qd_ok && !trip_d && en_q == EN_DONE;
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q   <= '0;
			gate_q <= 1'b0;
		end else begin
			en_q   <= en_d;
			gate_q <= gate_d;
		end
	end

	// Write channel: address and data taken in either order
	assign o_s_axi_awready = rst_n && !awf_q && !bv_q;
	assign o_s_axi_wready  = rst_n && !wf_q && !bv_q;
	assign aw_hs = i_s_axi_awvalid && o_s_axi_awready;
	assign w_hs  = i_s_axi_wvalid && o_s_axi_wready;

	always_comb begin
		awf_d  = awf_q || aw_hs;
		wf_d   = wf_q || w_hs;
		awa_d  = aw_hs ? i_s_axi_awaddr : awa_q;
		wd_d   = w_hs ? i_s_axi_wdata : wd_q;
		ws_d   = w_hs ? i_s_axi_wstrb : ws_q;
		bv_d   = bv_q && !i_s_axi_bready;
		br_d   = br_q;
		wr_go  = 1'b0;
		ctrl_d = ctrl_q;
		if (awf_d && wf_d && !bv_q) begin
			wr_go = 1'b1;
			awf_d = 1'b0;
			wf_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = is_map(awa_d) ? dess_pkg::RESP_OK : dess_pkg::RESP_ERR;
		end
		if (wr_go && awa_d == dess_pkg::A_CTRL) begin
			if (ws_d[0]) begin
				ctrl_d.qd_en  = wd_d[dess_pkg::CTRL_QD_EN];
				ctrl_d.cf_en  = wd_d[dess_pkg::CTRL_CF_EN];
				ctrl_d.qd_sel = wd_d[dess_pkg::CTRL_QD_SEL +: 3];
			end
			if (ws_d[1])
				ctrl_d.cf_sel = wd_d[dess_pkg::CTRL_CF_SEL +: 3];
		end
		clr = wr_go && awa_d == dess_pkg::A_RST && ws_d[0] &&
			wd_d[dess_pkg::RST_BIT];
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awf_q  <= 1'b0;
			wf_q   <= 1'b0;
			awa_q  <= 8'h00;
			wd_q   <= 32'h0000_0000;
			ws_q   <= 4'h0;
			bv_q   <= 1'b0;
			br_q   <= dess_pkg::RESP_OK;
			ctrl_q <= dess_pkg::CTRL_RST;
		end else begin
			awf_q  <= awf_d;
			wf_q   <= wf_d;
			awa_q  <= awa_d;
			wd_q   <= wd_d;
			ws_q   <= ws_d;
			bv_q   <= bv_d;
			br_q   <= br_d;
			ctrl_q <= ctrl_d;
		end
	end

	// Read channel: one read under way, data one cycle after address
	assign o_s_axi_arready = rst_n && !rv_q;
	assign ar_hs = i_s_axi_arvalid && o_s_axi_arready;

	always_comb begin
		rv_d = rv_q && !i_s_axi_rready;
		rd_d = rd_q;
		rr_d = rr_q;
		if (ar_hs) begin
			rv_d = 1'b1;
			rd_d = '0;
			rr_d = is_map(i_s_axi_araddr) ? dess_pkg::RESP_OK :
				dess_pkg::RESP_ERR;
			case (i_s_axi_araddr)
				dess_pkg::A_CTRL: begin
					rd_d[dess_pkg::CTRL_QD_EN]       = ctrl_q.qd_en;
					rd_d[dess_pkg::CTRL_CF_EN]       = ctrl_q.cf_en;
					rd_d[dess_pkg::CTRL_QD_SEL +: 3] = ctrl_q.qd_sel;
					rd_d[dess_pkg::CTRL_CF_SEL +: 3] = ctrl_q.cf_sel;
				end
				dess_pkg::A_STAT: begin
					rd_d[dess_pkg::ST_TC]       = tc;
					rd_d[dess_pkg::ST_QD]       = qd_in;
					rd_d[dess_pkg::ST_CF]       = cf_in;
					rd_d[dess_pkg::ST_TRIP]     = trip_q;
					rd_d[dess_pkg::ST_GATE]     = gate_q;
					rd_d[dess_pkg::ST_CMD]      = cmd_q;
					rd_d[dess_pkg::ST_WIN +: 2] = st_q;
				end
				dess_pkg::A_TRIP: begin
					rd_d[7:0]              = code_q;
					rd_d[dess_pkg::TR_ACT] = trip_q;
				end
				dess_pkg::A_LOG: rd_d = log_q;
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rv_q <= 1'b0;
			rd_q <= 32'h0000_0000;
			rr_q <= dess_pkg::RESP_OK;
		end else begin
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
		end
	end

	assign o_s_axi_bvalid  = bv_q;
	assign o_s_axi_bresp   = br_q;
	assign o_s_axi_rvalid  = rv_q;
	assign o_s_axi_rdata   = rd_q;
	assign o_s_axi_rresp   = rr_q;
	assign o_gate_enable   = gate_q;
	assign o_contactor_cmd = cmd_q;
	assign o_tripped       = trip_q;
	assign o_trip_code     = code_q;

	// Checks next to the logic they guard
	sequence s_start_late;
		st_q == dess_pkg::W_START && expire && !start_met &&
		!stop_ev && !sel_chg && !trip_q;
	endsequence
	sequence s_stop_late;
		st_q == dess_pkg::W_STOP && expire && !stop_met &&
		!start_ev && !trip_q;
	endsequence

	chk_start_window: assert property (s_start_late |=> trip_q)
		else $error("start window expiry did not trip");
	chk_stop_cutoff: assert property (s_stop_late ##0 tc |=>
		trip_q && code_q == dess_pkg::TRIP_TC)
		else $error("cutoff still closed after stop, wrong trip");
	chk_stop_qdis: assert property (s_stop_late ##0 (!tc &&
		!qd_off) |=> code_q == dess_pkg::TRIP_QD)
		else $error("quick-disable stuck, wrong trip");
	chk_current_decay: assert property (s_stop_late ##0 (!tc &&
		qd_off) |=> trip_q && code_q == dess_pkg::TRIP_CUR)
		else $error("current decay failure, wrong trip");
	chk_trip_hold: assert property (trip_q && !clr |=> trip_q)
		else $error("trip released without drive reset");
	chk_trip_log: assert property ($rose(trip_q) |->
		log_q[7:0] == code_q && !o_gate_enable)
		else $error("trip not logged or drive not held off");
	chk_contactor_fb: assert property (cset && !wset |=>
		trip_q && code_q == dess_pkg::TRIP_CF)
		else $error("contactor feedback fault not tripped");
	chk_cutoff_gate: assert property (!tc |=> !o_gate_enable ##1
		(!o_gate_enable || $past(tc)))
		else $error("output stage on with cutoff open");
	chk_quick_gate: assert property (ctrl_q.qd_en && !qd_in
		|=> !o_gate_enable)
		else $error("quick-disable did not stop output");
	chk_status_tc: assert property (ar_hs &&
		i_s_axi_araddr == dess_pkg::A_STAT |=>
		o_s_axi_rdata[dess_pkg::ST_TC] == $past(tc))
		else $error("status does not show cutoff state");
	chk_enable_delay: assert property ($rose(o_gate_enable)
		|-> $past(en_q) == EN_DONE)
		else $error("output enabled before sequencing delay");
endmodule

// >>> tb/dess_lift_model.sv
// Elevator controller model: travel relays, speeds, contactor aux
`timescale 1ns/100ps
module dess_lift_model (
	input  wire logic       i_core_clk,      // Drive clock
	input  wire logic       i_contactor_cmd, // Contactor close
	input  wire logic [2:0] i_qd_sel,        // Quick-disable input
	input  wire logic [2:0] i_cf_sel,        // Feedback input
	output logic            o_tc,            // Cutoff relay chain
	output logic [2:0]      o_speed_sel,     // Speed selection
	output logic [7:0]      o_din            // Digital inputs
);
	logic       qd_q;    // Separate quick-disable signal
	logic       ser_q;   // Series wiring
	logic       stuck_q; // Aux contact stuck
	logic       fb_q;    // Aux contact level
	logic [7:0] pat_q;   // Filler on unrouted inputs

	// Relays open at power up
	initial begin
		o_tc = 1'b0;
		o_speed_sel = 3'h0;
		qd_q = 1'b0;
		ser_q = 1'b0;
		stuck_q = 1'b0;
		fb_q = 1'b1;
		pat_q = 8'h5a;
	end

	// Unrouted inputs toggle so a misrouted input cannot pass
	always @(posedge i_core_clk) begin
		pat_q <= ~pat_q;
		fb_q <= stuck_q ? fb_q : !i_contactor_cmd; // Aux follows
	end

	always_comb begin
		o_din = pat_q;
		o_din[i_qd_sel] = ser_q ? o_tc : qd_q;
		o_din[i_cf_sel] = fb_q;
	end

	task automatic go(input logic [2:0] s);
		@(posedge i_core_clk);
		o_speed_sel <= s;
	endtask

	task automatic relays(input logic t, input logic q);
		@(posedge i_core_clk);
		o_tc <= t;
		qd_q <= q;
	endtask

	task automatic mode(input logic ser, input logic stuck);
		@(posedge i_core_clk);
		ser_q <= ser;
		stuck_q <= stuck;
	endtask
endmodule

// >>> tb/dess_supervisor_tb_top.sv
// Self-checking bench for the drive enable safety supervisor
`timescale 1ns/100ps
module dess_supervisor_tb_top;
	localparam int WIN = 40;
	localparam int ENS = 8;
	logic        clk, rst_n, awv, wv, bv, bre, arv, rv, rre;
	logic        awr, wr_rdy, arr, tc, gate, ccmd, tripped;
	logic [7:0]  awa, ara, din, code;
	logic [31:0] wd, rdat, ctrl, d;
	logic [3:0]  wst;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  spd;
	logic [11:0] cur;
	logic [7:0]  logq[$];
	int          err_count, n_checks, seed;

	// Free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	dess_supervisor #(.WIN_CYC(WIN), .ENSEQ_CYC(ENS)) dess_supervisor_inst (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_s_axi_awaddr(awa),
		.i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
		.i_s_axi_wstrb(wst), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy),
		.o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
		.i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
		.o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv),
		.i_s_axi_rready(rre), .i_torque_cutoff_input(tc), .i_speed_sel(spd),
		.i_din(din), .i_motor_current(cur), .o_gate_enable(gate),
		.o_contactor_cmd(ccmd), .o_tripped(tripped), .o_trip_code(code));

	dess_lift_model dess_lift_model_inst (
		.i_core_clk(clk), .i_contactor_cmd(ccmd), .i_qd_sel(ctrl[6:4]),
		.i_cf_sel(ctrl[10:8]), .o_tc(tc), .o_speed_sel(spd), .o_din(din));

	task automatic summarize;
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic bail;
		err_count++;
		$display("unexpected at %0t: wait ran out", $time);
		summarize();
	endtask

	// Write: both halves offered together, bready held until answer
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, bs;
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ta = awv & awr;
			tw = wv & wr_rdy;
			bs = bv;
			r = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (bs === 1'b1) begin
				bre <= 1'b0;
				return;
			end
		end
		bail();
	endtask

	task automatic rd(input logic [7:0] a);
		logic ta, rs;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ta = arv & arr;
			rs = rv;
			d = rdat;
			r = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
			if (rs === 1'b1) begin
				rre <= 1'b0;
				return;
			end
		end
		bail();
	endtask

	// Expect a latched trip, check log, then clear it
	task automatic trip_wait(input logic [7:0] e);
		int n;
		for (n = 0; n < 2 * WIN; n++) begin
			@(negedge clk);
			if (tripped === 1'b1) break;
		end
		if (n == 2 * WIN) bail();
		repeat (2) @(negedge clk);
		chk(code, e);
		chk(gate, 0);
		logq.push_front(e);
		void'(logq.pop_back());
		rd(dess_pkg::A_LOG);
		chk(d, {logq[3], logq[2], logq[1], logq[0]});
		rd(dess_pkg::A_TRIP);
		chk(d, 32'h100 | e);
		dess_lift_model_inst.go(0);
		dess_lift_model_inst.relays(0, 0);
		dess_lift_model_inst.mode(0, 0);
		cur <= 12'h0;
		repeat (10) @(posedge clk);
		chk(tripped, 1);
		wr(dess_pkg::A_RST, 1);
		repeat (4) @(negedge clk);
		chk(tripped, 0);
	endtask

	// Start with closures st/sq, stop opening pt/pq with low current cl
	task automatic travel(input logic st, sq, input logic [7:0] es,
		input logic pt, pq, cl, input logic [7:0] ep);
		dess_lift_model_inst.go(3'(1 + {$random(seed)} % 7));
		repeat (1 + {$random(seed)} % 10) @(posedge clk);
		chk(gate, 0);
		dess_lift_model_inst.relays(st, sq);
		if (es != 0) begin
			trip_wait(es);
			return;
		end
		repeat (8) @(negedge clk);
		chk(gate, 0);
		repeat (8) @(negedge clk);
		chk(gate, 1);
		chk(ccmd, 1);
		rd(dess_pkg::A_STAT);
		chk(d[dess_pkg::ST_TC], 1);
		@(posedge clk);
		cur <= cl ? 12'({$random(seed)} % 1023) : 12'hfff;
		dess_lift_model_inst.go(0);
		repeat (1 + {$random(seed)} % 10) @(posedge clk);
		dess_lift_model_inst.relays(1, !pq);
		repeat (7) @(negedge clk);
		if (pq) chk(gate, 0);
		dess_lift_model_inst.relays(!pt, !pq);
		if (ep != 0) begin
			trip_wait(ep);
			return;
		end
		repeat (2 * WIN) @(negedge clk);
		chk(tripped, 0);
		rd(dess_pkg::A_STAT);
		chk(d[dess_pkg::ST_TC], 0);
	endtask

	// Main sequence
	initial begin
		{awv, wv, bre, arv, rre, awa, ara, wd} = '0;
		wst = 4'hf;
		cur = 12'h0;
		ctrl = 32'h0;
		seed = 80;
		err_count = 0;
		n_checks = 0;
		logq = '{8'h0, 8'h0, 8'h0, 8'h0};
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(dess_pkg::A_CTRL);
		chk(d, 0);
		rd(8'h14);
		chk(r, dess_pkg::RESP_ERR);
		chk(d, 0);
		wr(8'h14, 32'h1);
		chk(r, dess_pkg::RESP_ERR);
		wr(dess_pkg::A_TRIP, 32'hff);
		chk(r, dess_pkg::RESP_OK);
		ctrl = 32'h523;
		wr(dess_pkg::A_CTRL, ctrl);
		rd(dess_pkg::A_CTRL);
		chk(d, ctrl);
		travel(1, 1, 0, 1, 1, 1, 0);
		travel(1, 1, 0, 1, 1, 1, 0);
		travel(0, 1, dess_pkg::TRIP_TC, 0, 0, 0, 0);
		travel(1, 0, dess_pkg::TRIP_QD, 0, 0, 0, 0);
		travel(1, 1, 0, 0, 1, 1, dess_pkg::TRIP_TC);
		travel(1, 1, 0, 1, 0, 1, dess_pkg::TRIP_QD);
		travel(1, 1, 0, 1, 1, 0, dess_pkg::TRIP_CUR);
		dess_lift_model_inst.go(1);
		repeat (6) @(posedge clk);
		dess_lift_model_inst.go(2);
		trip_wait(dess_pkg::TRIP_TC);
		dess_lift_model_inst.mode(0, 1);
		travel(1, 1, dess_pkg::TRIP_CF, 0, 0, 0, 0);
		wr(dess_pkg::A_CTRL, ctrl & 32'hfffffffd);
		dess_lift_model_inst.mode(0, 1);
		travel(1, 1, 0, 1, 1, 1, 0);
		// Series wiring: quick-disable follows the cutoff chain
		dess_lift_model_inst.mode(1, 0);
		travel(1, 0, 0, 1, 0, 1, 0);
		dess_lift_model_inst.mode(0, 0);
		summarize();
	end

	// Hang guard
	initial begin
		#1000000;
		bail();
	end
endmodule
